// ---- common/eeprom_pkg.sv ----
// Shared constants and types for the serial EEPROM slave interface
package eeprom_pkg;

  // ===========================================================================
  // Array geometry
  localparam int PAGE_BYTES    = 256;
  localparam int PAGE_COUNT    = 1024;
  localparam int ARRAY_BYTES   = PAGE_BYTES * PAGE_COUNT;
  localparam int ADDR_W        = 18;
  localparam int OFS_W         = 8;

  // ===========================================================================
  // Select byte layout
  localparam logic [2:0] SEL_TYPE_HI   = 3'h5;
  localparam int         SEL_TYPE_MSB  = 7;
  localparam int         SEL_TYPE_LSB  = 5;
  localparam int         SEL_ID_BIT    = 4;
  localparam int         SEL_CS_BIT    = 3;
  localparam int         SEL_A17_BIT   = 2;
  localparam int         SEL_A16_BIT   = 1;
  localparam int         SEL_RW_BIT    = 0;
  localparam int         LOCK_ADDR_BIT = 10;

  // ===========================================================================
  // Bit slot counter
  localparam logic [3:0] BIT_LAST      = 4'h7;
  localparam logic [3:0] BIT_ACK       = 4'h8;
  localparam logic [7:0] OFS_LAST      = 8'hFF;

  // ===========================================================================
  // Programming cycle timing
  localparam int PROG_TIME_NS   = 5000000;
  localparam int SYS_PERIOD_NS  = 40;
  localparam int PROG_CYCLES    = PROG_TIME_NS / SYS_PERIOD_NS;
  localparam int PROG_CNT_W     = 17;

  // ===========================================================================
  // Types
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_SEL     = 3'b001,
    ST_ADDR_HI = 3'b010,
    ST_ADDR_LO = 3'b011,
    ST_WDATA   = 3'b100,
    ST_RDATA   = 3'b101
  } link_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } bus_pins_t;

endpackage

// ---- core/serial_eeprom_slave.sv ----
// Serial EEPROM bus slave: protocol engine, page buffer, array and write timer
`timescale 1ns/10ps

module serial_eeprom_slave #(
  parameter int PROG_CYCLES = eeprom_pkg::PROG_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic link_clk,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  input  wire logic chip_select_strap,
  input  wire logic write_protect_input,
  output logic      prog_busy
);

  // ===========================================================================
  // Link domain: pin synchronisers
  eeprom_pkg::bus_pins_t pins_s1_q;
  eeprom_pkg::bus_pins_t pins_s2_q;
  eeprom_pkg::bus_pins_t pins_p_q;
  logic [1:0]            straps_s1_q;
  logic [1:0]            straps_s2_q;
  logic                  done_s1_q;
  logic                  done_s2_q;
  logic                  done_p_q;
  logic                  done_tgl_q;
  logic                  done_tgl_d;

  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      pins_s1_q   <= '{scl: 1'b1, sda: 1'b1};
      pins_s2_q   <= '{scl: 1'b1, sda: 1'b1};
      pins_p_q    <= '{scl: 1'b1, sda: 1'b1};
      straps_s1_q <= 2'h0;
      straps_s2_q <= 2'h0;
      done_s1_q   <= 1'b0;
      done_s2_q   <= 1'b0;
      done_p_q    <= 1'b0;
    end else begin
      pins_s1_q   <= '{scl: scl_in, sda: sda_in};
      pins_s2_q   <= pins_s1_q;
      pins_p_q    <= pins_s2_q;
      straps_s1_q <= {chip_select_strap, write_protect_input};
      straps_s2_q <= straps_s1_q;
      done_s1_q   <= done_tgl_q;
      done_s2_q   <= done_s1_q;
      done_p_q    <= done_s2_q;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic cs_level;
  logic wp_level;
  logic prog_done;

  // Strap floats low via pad pull-down, so it reads as 0
  assign cs_level   = straps_s2_q[1];
  assign wp_level   = straps_s2_q[0];
  // Bits sampled on rising, shifted out on falling clock
  assign scl_rise   = pins_s2_q.scl & ~pins_p_q.scl;
  assign scl_fall   = ~pins_s2_q.scl & pins_p_q.scl;
  assign start_seen = pins_s2_q.scl & pins_p_q.scl & pins_p_q.sda & ~pins_s2_q.sda;
  assign stop_seen  = pins_s2_q.scl & pins_p_q.scl & ~pins_p_q.sda & pins_s2_q.sda;
  assign prog_done  = done_s2_q ^ done_p_q;

  // ===========================================================================
  // Link domain: protocol state
  eeprom_pkg::link_state_t st_q;
  eeprom_pkg::link_state_t st_d;
  logic [3:0]              cnt_q;
  logic [3:0]              cnt_d;
  logic [7:0]              sh_q;
  logic [7:0]              sh_d;
  logic [7:0]              tx_q;
  logic [7:0]              tx_d;
  logic [17:0]             addr_q;
  logic [17:0]             addr_d;
  logic                    oe_q;
  logic                    oe_d;
  logic                    id_sel_q;
  logic                    id_sel_d;
  logic                    wr_pend_q;
  logic                    wr_pend_d;
  logic                    lock_pend_q;
  logic                    lock_pend_d;
  logic                    lock_q;
  logic                    lock_d;
  logic                    busy_q;
  logic                    busy_d;
  logic                    copy_q;
  logic                    copy_d;
  logic [7:0]              cp_idx_q;
  logic [7:0]              cp_idx_d;
  logic                    req_tgl_q;
  logic                    req_tgl_d;
  logic                    buf_we;
  logic                    buf_clr;
  logic [7:0]              rd_byte;

  logic [7:0] mem_q [eeprom_pkg::ARRAY_BYTES];
  logic [7:0] idpg_q [eeprom_pkg::PAGE_BYTES];
  logic [7:0] buf_q [eeprom_pkg::PAGE_BYTES];
  logic       bvalid_q [eeprom_pkg::PAGE_BYTES];

  assign rd_byte = id_sel_q ? idpg_q[addr_q[7:0]] : mem_q[addr_q];

  always_comb begin
    st_d        = st_q;
    cnt_d       = cnt_q;
    sh_d        = sh_q;
    tx_d        = tx_q;
    addr_d      = addr_q;
    oe_d        = oe_q;
    id_sel_d    = id_sel_q;
    wr_pend_d   = wr_pend_q;
    lock_pend_d = lock_pend_q;
    lock_d      = lock_q;
    busy_d      = busy_q;
    copy_d      = copy_q;
    cp_idx_d    = cp_idx_q;
    req_tgl_d   = req_tgl_q;
    buf_we      = 1'b0;
    buf_clr     = 1'b0;
    // Copy the page buffer into the array or the ID page, one byte per link cycle
    if (copy_q) begin
      cp_idx_d = cp_idx_q + 8'h01;
      if (cp_idx_q == eeprom_pkg::OFS_LAST) begin
        copy_d      = 1'b0;
        buf_clr     = 1'b1;
        lock_d      = lock_q | lock_pend_q;
        lock_pend_d = 1'b0;
      end
    end
    if (prog_done) begin
      busy_d = 1'b0;
    end
    if (start_seen) begin
      st_d  = eeprom_pkg::ST_SEL;
      // One below zero: the clock fall that closes a start ends no bit
      cnt_d = 4'hF;
      oe_d  = 1'b0;
    end else if (stop_seen) begin
      st_d  = eeprom_pkg::ST_IDLE;
      cnt_d = 4'h0;
      oe_d  = 1'b0;
      // Stop closing a write with an accepted data byte starts programming
      if (wr_pend_q && !busy_q) begin
        busy_d    = 1'b1;
        copy_d    = 1'b1;
        cp_idx_d  = 8'h00;
        req_tgl_d = ~req_tgl_q;
        wr_pend_d = 1'b0;
      end
    end else if (st_q != eeprom_pkg::ST_IDLE) begin
      if (scl_rise && cnt_q < eeprom_pkg::BIT_ACK) begin
        sh_d = {sh_q[6:0], pins_s2_q.sda};
      end
      // Master leaving the ack slot high ends the read
      if (scl_rise && cnt_q == eeprom_pkg::BIT_ACK && st_q == eeprom_pkg::ST_RDATA
          && pins_s2_q.sda) begin
        st_d = eeprom_pkg::ST_IDLE;
      end
      if (scl_fall) begin
        if (cnt_q == eeprom_pkg::BIT_LAST) begin
          cnt_d = eeprom_pkg::BIT_ACK;
          oe_d  = 1'b0;
          case (st_q)
            eeprom_pkg::ST_SEL: begin
              if (sh_q[eeprom_pkg::SEL_TYPE_MSB:eeprom_pkg::SEL_TYPE_LSB]
                  == eeprom_pkg::SEL_TYPE_HI && sh_q[eeprom_pkg::SEL_CS_BIT] == cs_level
                  && !busy_q) begin
                oe_d     = 1'b1;
                id_sel_d = sh_q[eeprom_pkg::SEL_ID_BIT];
                if (sh_q[eeprom_pkg::SEL_RW_BIT]) begin
                  st_d = eeprom_pkg::ST_RDATA;
                end else begin
                  st_d          = eeprom_pkg::ST_ADDR_HI;
                  addr_d[17:16] = {sh_q[eeprom_pkg::SEL_A17_BIT], sh_q[eeprom_pkg::SEL_A16_BIT]};
                end
              end else begin
                st_d = eeprom_pkg::ST_IDLE;
              end
            end
            eeprom_pkg::ST_ADDR_HI: begin
              // Address bytes are acknowledged regardless of protect
              oe_d         = 1'b1;
              addr_d[15:8] = sh_q;
              st_d         = eeprom_pkg::ST_ADDR_LO;
            end
            eeprom_pkg::ST_ADDR_LO: begin
              oe_d        = 1'b1;
              addr_d[7:0] = sh_q;
              st_d        = eeprom_pkg::ST_WDATA;
            end
            eeprom_pkg::ST_WDATA: begin
              // Protect gates data ack and storage
              if (!wp_level && !(id_sel_q && lock_q)) begin
                oe_d      = 1'b1;
                wr_pend_d = 1'b1;
                if (id_sel_q && addr_q[eeprom_pkg::LOCK_ADDR_BIT]) begin
                  lock_pend_d = 1'b1;
                end else begin
                  buf_we = 1'b1;
                end
                addr_d[7:0] = addr_q[7:0] + 8'h01;
              end
            end
            default: begin
              oe_d = 1'b0;
            end
          endcase
        end else if (cnt_q == eeprom_pkg::BIT_ACK) begin
          cnt_d = 4'h0;
          oe_d  = 1'b0;
          if (st_q == eeprom_pkg::ST_RDATA) begin
            // Zero bits pull low, one bits release
            tx_d   = {rd_byte[6:0], 1'b0};
            oe_d   = ~rd_byte[7];
            addr_d = addr_q + 18'h00001;
          end
        end else begin
          cnt_d = cnt_q + 4'h1;
          if (st_q == eeprom_pkg::ST_RDATA) begin
            oe_d = ~tx_q[7];
            tx_d = {tx_q[6:0], 1'b0};
          end
        end
      end
    end
  end

  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      st_q        <= eeprom_pkg::ST_IDLE;
      cnt_q       <= 4'h0;
      sh_q        <= 8'h00;
      tx_q        <= 8'h00;
      addr_q      <= 18'h00000;
      oe_q        <= 1'b0;
      id_sel_q    <= 1'b0;
      wr_pend_q   <= 1'b0;
      lock_pend_q <= 1'b0;
      lock_q      <= 1'b0;
      busy_q      <= 1'b0;
      copy_q      <= 1'b0;
      cp_idx_q    <= 8'h00;
      req_tgl_q   <= 1'b0;
    end else begin
      st_q        <= st_d;
      cnt_q       <= cnt_d;
      sh_q        <= sh_d;
      tx_q        <= tx_d;
      addr_q      <= addr_d;
      oe_q        <= oe_d;
      id_sel_q    <= id_sel_d;
      wr_pend_q   <= wr_pend_d;
      lock_pend_q <= lock_pend_d;
      lock_q      <= lock_d;
      busy_q      <= busy_d;
      copy_q      <= copy_d;
      cp_idx_q    <= cp_idx_d;
      req_tgl_q   <= req_tgl_d;
    end
  end

  // ===========================================================================
  // Storage: page buffer, main array and ID page
  // Array cells carry no reset; only the buffer valid flags do
  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < eeprom_pkg::PAGE_BYTES; i++) begin
        bvalid_q[i] <= 1'b0;
      end
    end else if (buf_clr) begin
      for (int i = 0; i < eeprom_pkg::PAGE_BYTES; i++) begin
        bvalid_q[i] <= 1'b0;
      end
    end else if (buf_we) begin
      bvalid_q[addr_q[7:0]] <= 1'b1;
    end
  end

  // Commit buffered bytes into the selected page
  always_ff @(posedge link_clk) begin
    if (buf_we) begin
      buf_q[addr_q[7:0]] <= sh_q;
    end
    if (copy_q && bvalid_q[cp_idx_q]) begin
      if (id_sel_q) begin
        idpg_q[cp_idx_q] <= buf_q[cp_idx_q];
      end else begin
        mem_q[{addr_q[17:8], cp_idx_q}] <= buf_q[cp_idx_q];
      end
    end
  end

  // ===========================================================================
  // Pin drivers
  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      sda_out <= 1'b0;
      sda_oe  <= 1'b0;
    end else begin
      // Output level is always low; only the enable moves
      sda_out <= 1'b0;
      sda_oe  <= oe_d;
    end
  end

  // ===========================================================================
  // System domain: programming cycle timer
  logic                              req_s1_q;
  logic                              req_s2_q;
  logic                              req_p_q;
  logic [eeprom_pkg::PROG_CNT_W-1:0] tmr_q;
  logic [eeprom_pkg::PROG_CNT_W-1:0] tmr_d;

  // Count the cycle length, then hand completion back
  always_comb begin
    tmr_d      = tmr_q;
    done_tgl_d = done_tgl_q;
    if (req_s2_q ^ req_p_q) begin
      tmr_d = eeprom_pkg::PROG_CNT_W'(PROG_CYCLES);
    end else if (tmr_q != '0) begin
      tmr_d = tmr_q - eeprom_pkg::PROG_CNT_W'(1);
      if (tmr_q == eeprom_pkg::PROG_CNT_W'(1)) begin
        done_tgl_d = ~done_tgl_q;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      req_s1_q   <= 1'b0;
      req_s2_q   <= 1'b0;
      req_p_q    <= 1'b0;
      tmr_q      <= '0;
      done_tgl_q <= 1'b0;
      prog_busy  <= 1'b0;
    end else begin
      req_s1_q   <= req_tgl_q;
      req_s2_q   <= req_s1_q;
      req_p_q    <= req_s2_q;
      tmr_q      <= tmr_d;
      done_tgl_q <= done_tgl_d;
      prog_busy  <= (tmr_d != '0);
    end
  end

endmodule // serial_eeprom_slave

// ---- testbench/serial_eeprom_slave_assertions.sv ----
// Assertion checker bound to the serial EEPROM slave
`timescale 1ns/10ps
module eeprom_slave_checker #(
  parameter int PROG_CYCLES = 200
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic chip_select_strap,
  input wire logic write_protect_input,
  input wire logic prog_busy
);
  // ====================
  // Busy length counter
  logic [31:0] hi_cnt_q;
  logic [31:0] hi_cnt_d;
  always_comb hi_cnt_d = prog_busy ? hi_cnt_q + 32'h1 : 32'h0;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) hi_cnt_q <= 32'h0;
    else hi_cnt_q <= hi_cnt_d;
  end
  // ====================
  // Link side
  // never drives high
  a_out_low_only: assert property (
    @(posedge link_clk) disable iff (!rstn) sda_out == 1'b0) else $error("sda_out not low");
  a_oe_on_low: assert property (
    @(posedge link_clk) disable iff (!rstn) $changed(sda_oe) |-> !$past(scl_in, 2))
    else $error("sda_oe moved with clock high");
  a_oe_hold: assert property (
    @(posedge link_clk) disable iff (!rstn) $rose(sda_oe) |-> sda_oe [*8])
    else $error("sda_oe pulse too short");
  a_busy_no_ack: assert property (
    @(posedge link_clk) disable iff (!rstn) prog_busy && $past(prog_busy) |-> !sda_oe)
    else $error("answered while programming");
  a_stop_starts: assert property (
    @(posedge link_clk) disable iff (!rstn) $rose(prog_busy) |-> scl_in && sda_in)
    else $error("programming began on busy bus");
  // ====================
  // Timer side
  // programming length
  a_busy_length: assert property (
    @(posedge sys_clk) disable iff (!rstn) $fell(prog_busy) |->
      hi_cnt_q >= PROG_CYCLES - 1 && hi_cnt_q <= PROG_CYCLES + 1)
    else $error("programming length wrong");
  a_protect_blocks: assert property (
    @(posedge sys_clk) disable iff (!rstn) $rose(prog_busy) |-> !$past(write_protect_input, 8))
    else $error("programming under protect");
  a_reset_quiet: assert property (
    @(posedge sys_clk) disable iff (!rstn) $rose(rstn) |-> !sda_oe && !prog_busy)
    else $error("outputs active after reset");
  c_ack: cover property (@(posedge link_clk) disable iff (!rstn) $rose(sda_oe));
  c_prog: cover property (@(posedge sys_clk) disable iff (!rstn) $fell(prog_busy));
  c_poll: cover property (@(posedge link_clk) disable iff (!rstn) prog_busy && !scl_in);
endmodule // eeprom_slave_checker

bind serial_eeprom_slave eeprom_slave_checker #(.PROG_CYCLES(PROG_CYCLES)) chk_i (
  .sys_clk(sys_clk), .rstn(rstn), .link_clk(link_clk), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .chip_select_strap(chip_select_strap), .write_protect_input(write_protect_input),
  .prog_busy(prog_busy));

// ---- testbench/i2c_master_model.sv ----
// Behavioural bus master that moves bytes to and from the slave
`timescale 1ns/10ps
module i2c_master_model #(
  parameter int HALF = 8
) (
  input  wire logic       link_clk,
  input  wire logic       sda_wire,
  output logic            scl,
  output logic            sda_low,
  output logic [8:0]      res,
  output logic            res_v
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    res = 9'h000;
    res_v = 1'b0;
  end
  // Every change lands just after a link edge
  task automatic wt(input int n);
    repeat (n) @(posedge link_clk);
    #1;
  endtask
  task automatic start();
    sda_low = 1'b0;
    wt(HALF);
    scl = 1'b1;
    wt(HALF);
    sda_low = 1'b1;
    wt(HALF);
    scl = 1'b0;
    wt(HALF);
  endtask
  task automatic stop();
    sda_low = 1'b1;
    wt(HALF);
    scl = 1'b1;
    wt(HALF);
    sda_low = 1'b0;
    wt(HALF);
  endtask
  // Data moves two cycles after the fall so it never races the clock edge
  task automatic bit_io(input logic b, output logic s);
    sda_low = ~b;
    wt(HALF);
    scl = 1'b1;
    wt(HALF);
    s = sda_wire;
    scl = 1'b0;
    wt(2);
  endtask
  task automatic post(input logic [8:0] v);
    res = v;
    res_v = 1'b1;
    wt(1);
    res_v = 1'b0;
  endtask
  task automatic tx(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(d[i], a);
    bit_io(1'b1, a);
    post({d, a});
  endtask
  task automatic rx(input logic mack);
    logic [7:0] d;
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(mack, a);
    post({d, mack});
  endtask
endmodule // i2c_master_model

// ---- testbench/serial_eeprom_slave_interface_bench.sv ----
// Self-checking bench for the serial EEPROM slave
`timescale 1ns/10ps
module serial_eeprom_slave_interface_bench;
  logic        sys_clk = 1'b0;
  logic        link_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        cs = 1'b0;
  logic        wp = 1'b0;
  logic        sda_out;
  logic        sda_oe;
  logic        prog_busy;
  logic        scl;
  logic        sda_low;
  logic        sda_wire;
  logic [8:0]  res;
  logic        res_v;
  logic [8:0]  exp_q[$];
  logic [31:0] seed = 32'hDFD1245E;
  int          errors = 0;
  int          tests_run = 0;
  always #20 sys_clk = ~sys_clk;
  always #6 link_clk = ~link_clk;
  assign sda_wire = ~((sda_oe & ~sda_out) | sda_low);
  serial_eeprom_slave #(.PROG_CYCLES(200)) dut (
    .sys_clk(sys_clk), .rstn(rstn), .link_clk(link_clk), .scl_in(scl),
    .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_strap(cs),
    .write_protect_input(wp), .prog_busy(prog_busy));
  i2c_master_model m (.link_clk(link_clk), .sda_wire(sda_wire), .scl(scl),
    .sda_low(sda_low), .res(res), .res_v(res_v));
  // ====================
  // Helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [8:0] seen, input logic [8:0] want);
    tests_run++;
    if (seen !== want) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, want);
    end
  endtask
  task automatic conclude();
    if (errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge link_clk) begin
    if (res_v === 1'b1) begin
      if (exp_q.size() == 0) check(res, ~res);
      else check(res, exp_q.pop_front());
    end
  end
  task automatic snd(input logic [7:0] d, input logic ack);
    exp_q.push_back({d, ~ack});
    m.tx(d);
  endtask
  task automatic rcv(input logic [7:0] d, input logic mack);
    exp_q.push_back({d, mack});
    m.rx(mack);
  endtask
  function automatic logic [7:0] sel(input logic [3:0] t, input logic [1:0] h, input logic r);
    return {t, cs, h, r};
  endfunction
  task automatic hdr(input logic [3:0] t, input logic [9:0] pg, input logic [7:0] ofs);
    m.start();
    snd(sel(t, pg[9:8], 1'b0), 1'b1);
    snd(pg[7:0], 1'b1);
    snd(ofs, 1'b1);
  endtask
  task automatic rd_at(input logic [3:0] t, input logic [9:0] pg, input logic [7:0] ofs);
    hdr(t, pg, ofs);
    m.start();
    snd(sel(t, pg[9:8], 1'b1), 1'b1);
  endtask
  task automatic await_busy(input logic lvl, input int lim);
    int n;
    n = 0;
    while (prog_busy !== lvl) begin
      m.wt(1);
      n++;
      if (n > lim) begin
        errors++;
        conclude();
      end
    end
  endtask
  task automatic prog_wait();
    await_busy(1'b1, 800);
    m.start();
    snd(sel(4'hA, 2'h0, 1'b0), 1'b0);
    m.stop();
    await_busy(1'b0, 2000);
    m.wt(20);
  endtask
  // ====================
  // Main sequence
  initial begin
    logic [31:0] r;
    logic [9:0]  pg;
    logic [7:0]  d[3];
    repeat (5) @(posedge sys_clk);
    #1 rstn = 1'b1;
    m.wt(8);
    for (int s = 0; s < 2; s++) begin
      cs = s[0];
      m.wt(4);
      for (int j = 0; j < 32; j++) begin
        m.start();
        snd({j[4:1], j[0], 3'h0}, (j[4:1] == 4'hA || j[4:1] == 4'hB) && j[0] == cs);
        m.stop();
      end
    end
    r = xs();
    pg = r[9:0];
    d[0] = r[31:24];
    d[1] = r[23:16];
    d[2] = r[17:10];
    hdr(4'hA, pg, 8'hFE);
    for (int i = 0; i < 3; i++) snd(d[i], 1'b1);
    m.stop();
    prog_wait();
    rd_at(4'hA, pg, 8'hFE);
    rcv(d[0], 1'b0);
    rcv(d[1], 1'b1);
    m.stop();
    rd_at(4'hA, pg, 8'h00);
    rcv(d[2], 1'b1);
    m.stop();
    wp = 1'b1;
    hdr(4'hA, pg, 8'hFE);
    snd(~d[0], 1'b0);
    m.stop();
    m.wt(400);
    check({8'h00, prog_busy}, 9'h000);
    wp = 1'b0;
    m.wt(4);
    rd_at(4'hA, pg, 8'hFE);
    rcv(d[0], 1'b1);
    m.stop();
    hdr(4'hB, 10'h000, 8'h10);
    snd(d[1], 1'b1);
    m.stop();
    prog_wait();
    hdr(4'hB, 10'h004, 8'h00);
    snd(8'h00, 1'b1);
    m.stop();
    prog_wait();
    hdr(4'hB, 10'h000, 8'h10);
    snd(~d[1], 1'b0);
    m.stop();
    m.wt(20);
    rd_at(4'hB, 10'h000, 8'h10);
    rcv(d[1], 1'b1);
    m.stop();
    m.wt(20);
    conclude();
  end
endmodule // serial_eeprom_slave_interface_bench
